// >>> shared/dbgct_defs.vh
`ifndef DBGCT_DEFS_VH
`define DBGCT_DEFS_VH

// Register select indices on the register port
`define DBGCT_IDX_CMP_A_HIGH 3'h0
`define DBGCT_IDX_CMP_A_LOW 3'h1
`define DBGCT_IDX_CMP_B_HIGH 3'h2
`define DBGCT_IDX_CMP_B_LOW 3'h3
`define DBGCT_IDX_FIFO_HIGH 3'h4
`define DBGCT_IDX_FIFO_LOW 3'h5
`define DBGCT_IDX_CONTROL 3'h6

// Reset values
`define DBGCT_RST_BYTE 8'h00
`define DBGCT_RST_WORD 16'h0000
`define DBGCT_RST_CNT 4'h0

// Control register bit positions
`define DBGCT_BIT_ENABLE 7
`define DBGCT_BIT_ARM 6
`define DBGCT_BIT_TAG 5
`define DBGCT_BIT_BREAK_REQUEST_ENABLE 4
`define DBGCT_BIT_DIR_A 3
`define DBGCT_BIT_QUAL_A 2
`define DBGCT_BIT_DIR_B 1
`define DBGCT_BIT_QUAL_B 0

// Trace depth and count values
`define DBGCT_FIFO_DEPTH 8
`define DBGCT_CNT_FULL 4'h8
`define DBGCT_CNT_LAST 4'h7

// Trigger mode codes
`define DBGCT_MODE_A_ONLY 4'h0
`define DBGCT_MODE_A_OR_B 4'h1
`define DBGCT_MODE_A_THEN_B 4'h2
`define DBGCT_MODE_EVENT_B 4'h3
`define DBGCT_MODE_A_THEN_EVENT_B 4'h4
`define DBGCT_MODE_A_AND_BDATA 4'h5
`define DBGCT_MODE_A_NOT_BDATA 4'h6
`define DBGCT_MODE_INSIDE 4'h7
`define DBGCT_MODE_OUTSIDE 4'h8

`endif

// >>> rtl/dbgct_regs.v
`timescale 1ns/100ps
`include "dbgct_defs.vh"

// How it works
// - Two 16-bit compare values, byte registers, reset zero
// - Compare byte writes ignored while armed
// - High port shows upper byte, no advance
// - Low port read advances to next word
// - Event-only modes store bytes, high reads zero
// - Armed low reads never advance the trace
// - Unarmed low read captures last opcode address
// - Unarmed trace is eight-deep delay line
// - Control register always readable and writable
// - Enable bit 7, not settable when secure
// - Arm bit 6, auto clear, manual stop
// - Bit 5 picks tag or force break
// - Bit 4 enables break at run end
// - Trace storage independent of break enable
// - Bits 3:2 qualify comparator A direction
// - Bits 1:0 qualify comparator B direction
// - Begin run ends on full, end run on its trigger
// - Modes 0011 and 0100 are event-only
module dbgct_regs #(
    parameter DEPTH = `DBGCT_FIFO_DEPTH
) (
    input wire sys_clk,
    input wire reset,
    input wire [2:0] reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire secure,
    input wire [3:0] trigger_mode,
    input wire begin_trace,
    input wire opcode_qualified_trigger,
    input wire bus_valid,
    input wire bus_read,
    input wire bus_fetch,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_data,
    output reg break_request,
    output reg break_is_tag,
    output wire armed_flag,
    output reg match_a_flag,
    output reg match_b_flag,
    output reg [3:0] fifo_count
);

    reg [7:0] compare_a_high_byte;
    reg [7:0] compare_a_low_byte;
    reg [7:0] compare_b_high_byte;
    reg [7:0] compare_b_low_byte;
    reg module_enable;
    reg arm;
    reg tag_select;
    reg break_request_enable;
    reg direction_value_a;
    reg direction_qualify_a;
    reg direction_value_b;
    reg direction_qualify_b;
    reg [15:0] trace_word [0:DEPTH-1];
    reg [15:0] last_fetch;
    reg a_seen;
    reg triggered;
    reg [15:0] store_word;
    reg trig_cond;
    reg [7:0] next_rdata;
    wire [15:0] cmp_a;
    wire [15:0] cmp_b;
    wire wr_ctrl;
    wire wr_cmp;
    wire rd_low;
    wire next_enable;
    wire next_arm;
    wire run_start;
    wire event_only;
    wire begin_eff;
    wire qual_ok;
    wire match_a;
    wire match_b;
    wire trig_hit;
    wire store;
    wire end_run;
    wire advance;
    wire [7:0] ctrl_value;
    integer i;

    // Direction check shared by both comparators
    // A cleared qualify bit lets either direction through
    function dir_ok;
        input qualify;
        input dir_value;
        input rd;
        begin
            dir_ok = !qualify || (rd == dir_value);
        end
    endfunction

    // Joined compare values
    // Written high and low bytes form the word the bus sees
    // byte pairs joined
    assign cmp_a = {compare_a_high_byte, compare_a_low_byte};
    assign cmp_b = {compare_b_high_byte, compare_b_low_byte};

    // Register port strobes
    // FIFO ports and the spare index decode to no write at all
    assign wr_ctrl = reg_wr && (reg_sel == `DBGCT_IDX_CONTROL);
    assign wr_cmp = reg_wr && !arm;
    assign rd_low = reg_rd && (reg_sel == `DBGCT_IDX_FIFO_LOW);

    // Control write decode
    // Enable may stay set while secure; it only cannot rise
    // Arm lands only if the enable from the same write is set
    // secure blocks setting enable
    assign next_enable = reg_wdata[`DBGCT_BIT_ENABLE] && (!secure || module_enable);
    assign next_arm = reg_wdata[`DBGCT_BIT_ARM] && next_enable;
    assign run_start = wr_ctrl && next_arm && !arm;
    assign armed_flag = arm;

    // Mode decode
    // Event-only modes always run as begin traces
    // event-only modes
    assign event_only = (trigger_mode == `DBGCT_MODE_EVENT_B) ||
                        (trigger_mode == `DBGCT_MODE_A_THEN_EVENT_B);
    assign begin_eff = begin_trace || event_only;

    // Comparator matches, optionally on opcode fetches only
    // Nothing matches while disarmed, so idle flags stay put
    assign qual_ok = bus_valid && arm && (!opcode_qualified_trigger || bus_fetch);
    assign match_a = qual_ok && (bus_addr == cmp_a) &&
                     dir_ok(direction_qualify_a, direction_value_a, bus_read);
    assign match_b = qual_ok && (bus_addr == cmp_b) &&
                     dir_ok(direction_qualify_b, direction_value_b, bus_read);

    // Trigger condition per mode
    // Spare codes never trigger; such a run ends by software
    // compare each armed bus cycle
    always @* begin
        case (trigger_mode)
            `DBGCT_MODE_A_ONLY: trig_cond = match_a;
            `DBGCT_MODE_A_OR_B: trig_cond = match_a || match_b;
            `DBGCT_MODE_A_THEN_B: trig_cond = a_seen && match_b;
            `DBGCT_MODE_EVENT_B: trig_cond = match_b;
            `DBGCT_MODE_A_THEN_EVENT_B: trig_cond = a_seen && match_b;
            `DBGCT_MODE_A_AND_BDATA: trig_cond = match_a && (bus_data == compare_b_low_byte);
            `DBGCT_MODE_A_NOT_BDATA: trig_cond = match_a && (bus_data != compare_b_low_byte);
            `DBGCT_MODE_INSIDE: trig_cond = qual_ok && (bus_addr >= cmp_a) && (bus_addr <= cmp_b);
            `DBGCT_MODE_OUTSIDE: trig_cond = qual_ok && ((bus_addr < cmp_a) || (bus_addr > cmp_b));
            default: trig_cond = 1'b0;
        endcase
    end
    // A trigger counts only while armed
    assign trig_hit = arm && trig_cond;

    // What enters the trace and when
    // End traces keep every fetch; begin traces start after trigger
    // The trigger fetch itself is not stored in a begin trace
    always @* begin
        store_word = bus_addr;
        if (event_only) begin
            store_word = {8'h00, bus_data};
        end
    end
    assign store = arm && (event_only ? trig_cond :
                   (bus_valid && bus_fetch && (!begin_trace || triggered)));

    // The eighth store fills the trace and closes a begin run
    // run end
    assign end_run = arm && ((begin_eff && store && (fifo_count == `DBGCT_CNT_LAST)) ||
                     (!begin_eff && trig_hit));

    // Armed reads still return word 0, only the shift is held
    // no advance while armed
    assign advance = rd_low && !arm;

    // Comparator byte registers
    // reset zero, read anytime
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            compare_a_high_byte <= `DBGCT_RST_BYTE;
            compare_a_low_byte <= `DBGCT_RST_BYTE;
            compare_b_high_byte <= `DBGCT_RST_BYTE;
            compare_b_low_byte <= `DBGCT_RST_BYTE;
        end else if (wr_cmp) begin
            case (reg_sel)
                `DBGCT_IDX_CMP_A_HIGH: compare_a_high_byte <= reg_wdata;
                `DBGCT_IDX_CMP_A_LOW: compare_a_low_byte <= reg_wdata;
                `DBGCT_IDX_CMP_B_HIGH: compare_b_high_byte <= reg_wdata;
                `DBGCT_IDX_CMP_B_LOW: compare_b_low_byte <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Control register; a software write outranks run completion
    // Setup bits change only by software, never by a run
    // always writable
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            module_enable <= 1'b0;
            arm <= 1'b0;
            tag_select <= 1'b0;
            break_request_enable <= 1'b0;
            direction_value_a <= 1'b0;
            direction_qualify_a <= 1'b0;
            direction_value_b <= 1'b0;
            direction_qualify_b <= 1'b0;
        end else if (wr_ctrl) begin
            module_enable <= next_enable;
            arm <= next_arm;
            tag_select <= reg_wdata[`DBGCT_BIT_TAG];
            break_request_enable <= reg_wdata[`DBGCT_BIT_BREAK_REQUEST_ENABLE];
            direction_value_a <= reg_wdata[`DBGCT_BIT_DIR_A];
            direction_qualify_a <= reg_wdata[`DBGCT_BIT_QUAL_A];
            direction_value_b <= reg_wdata[`DBGCT_BIT_DIR_B];
            direction_qualify_b <= reg_wdata[`DBGCT_BIT_QUAL_B];
        end else if (end_run) begin
            arm <= 1'b0;
        end
    end

    // Run state: A-seen, begin trigger seen, valid count, match flags
    // Flags clear only on a fresh arm, which no match can meet
    // The count saturates so a long end trace reads as full
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            a_seen <= 1'b0;
            triggered <= 1'b0;
            fifo_count <= `DBGCT_RST_CNT;
            match_a_flag <= 1'b0;
            match_b_flag <= 1'b0;
        end else if (run_start) begin
            a_seen <= 1'b0;
            triggered <= 1'b0;
            fifo_count <= `DBGCT_RST_CNT;
            match_a_flag <= 1'b0;
            match_b_flag <= 1'b0;
        end else begin
            if (match_a) begin
                a_seen <= 1'b1;
                match_a_flag <= 1'b1;
            end
            if (match_b) begin
                match_b_flag <= 1'b1;
            end
            if (trig_hit && begin_trace) begin
                triggered <= 1'b1;
            end
            if (store && (fifo_count != `DBGCT_CNT_FULL)) begin
                fifo_count <= fifo_count + 4'h1;
            end
        end
    end

    // Most recent opcode fetch address
    // Profiling reads take this value, one cycle old at most
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_fetch <= `DBGCT_RST_WORD;
        end else if (bus_valid && bus_fetch) begin
            last_fetch <= bus_addr;
        end
    end

    // Trace shift register: word 0 is the current read word
    // Store needs arm and advance needs no arm, so they never meet
    // low read shifts
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                trace_word[i] <= `DBGCT_RST_WORD;
            end
        end else if (store || advance) begin
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                trace_word[i] <= trace_word[i + 1];
            end
            trace_word[DEPTH - 1] <= store ? store_word : last_fetch;
        end
    end

    // Break request pulse at the end of a run
    // Tag type is latched with the pulse so it reads back steady
    // break when enabled
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            break_request <= 1'b0;
            break_is_tag <= 1'b0;
        end else begin
            break_request <= end_run && break_request_enable;
            if (end_run && break_request_enable) begin
                break_is_tag <= tag_select;
            end
        end
    end

    // Read data selection
    assign ctrl_value = {module_enable, arm, tag_select, break_request_enable,
                         direction_value_a, direction_qualify_a,
                         direction_value_b, direction_qualify_b};
    always @* begin
        case (reg_sel)
            `DBGCT_IDX_CMP_A_HIGH: next_rdata = compare_a_high_byte;
            `DBGCT_IDX_CMP_A_LOW: next_rdata = compare_a_low_byte;
            `DBGCT_IDX_CMP_B_HIGH: next_rdata = compare_b_high_byte;
            `DBGCT_IDX_CMP_B_LOW: next_rdata = compare_b_low_byte;
            // zero in event-only modes
            // Profiling shifts can leave addresses there; hide them
            `DBGCT_IDX_FIFO_HIGH: next_rdata = event_only ? 8'h00 : trace_word[0][15:8];
            `DBGCT_IDX_FIFO_LOW: next_rdata = trace_word[0][7:0];
            `DBGCT_IDX_CONTROL: next_rdata = ctrl_value;
            // Spare index reads zero
            default: next_rdata = 8'h00;
        endcase
    end

    // Registered read data, captured before any shift
    // Holding between reads lets a slow host fetch the byte late
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `DBGCT_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // dbgct_regs

// >>> dv/dbgct_regs_monitor.sv
`timescale 1ns/100ps
`include "dbgct_defs.vh"
// Checks run start, run end and break pulses at the ports
module dbgct_regs_monitor (
    input wire sys_clk,
    input wire reset,
    input wire [2:0] reg_sel,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire secure,
    input wire [3:0] trigger_mode,
    input wire begin_trace,
    input wire break_request,
    input wire armed_flag,
    input wire match_a_flag,
    input wire match_b_flag,
    input wire [3:0] fifo_count
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Control writes that start or stop a run
    sequence s_arm_wr;
        reg_wr && reg_sel == `DBGCT_IDX_CONTROL && reg_wdata[7:6] == 2'b11 && !secure;
    endsequence
    sequence s_stop_wr;
        reg_wr && reg_sel == `DBGCT_IDX_CONTROL && reg_wdata[7:6] != 2'b11;
    endsequence
    property p_arm; s_arm_wr |=> armed_flag; endproperty
    a_arm: assert property (p_arm) else $error("arm write did not arm");
    property p_stop; s_stop_wr |=> !armed_flag; endproperty
    a_stop: assert property (p_stop) else $error("stop write left run armed");
    property p_run_clear; $rose(armed_flag) |-> !match_a_flag && !match_b_flag && fifo_count == 4'h0; endproperty
    a_run_clear: assert property (p_run_clear) else $error("run start left flags set");
    property p_brk_src; break_request |-> $past(armed_flag) && !armed_flag; endproperty
    a_brk_src: assert property (p_brk_src) else $error("break without run end");
    property p_brk_pulse; break_request |=> !break_request; endproperty
    a_brk_pulse: assert property (p_brk_pulse) else $error("break longer than one cycle");
    property p_end_trig;
        (($rose(match_a_flag) && trigger_mode <= 4'h1) || ($rose(match_b_flag) && trigger_mode == 4'h1)) &&
            !begin_trace |-> !armed_flag;
    endproperty
    a_end_trig: assert property (p_end_trig) else $error("end trace trigger kept run");
    property p_full_end;
        fifo_count == 4'h8 && $past(fifo_count) == 4'h7 && (begin_trace || trigger_mode == 4'h3 ||
            trigger_mode == 4'h4) |-> !armed_flag;
    endproperty
    a_full_end: assert property (p_full_end) else $error("full trace kept run");
    property p_cnt_max; fifo_count <= 4'h8; endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("count above depth");
endmodule // dbgct_regs_monitor

bind dbgct_regs dbgct_regs_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .secure(secure), .trigger_mode(trigger_mode),
    .begin_trace(begin_trace), .break_request(break_request), .armed_flag(armed_flag),
    .match_a_flag(match_a_flag), .match_b_flag(match_b_flag), .fifo_count(fifo_count));

// >>> dv/dbgct_cpu_model.sv
`timescale 1ns/100ps
// CPU bus side: one cycle per call, idle lines scrambled
module dbgct_cpu_model (
    input wire sys_clk,
    output reg bus_valid = 1'b0,
    output reg bus_read = 1'b0,
    output reg bus_fetch = 1'b0,
    output reg [15:0] bus_addr = 16'h0000,
    output reg [7:0] bus_data = 8'h00
);
    // Cycle held across one sampling edge
    task cyc(input [15:0] a, input r, input f, input [7:0] d);
        begin
            @(posedge sys_clk);
            #1;
            bus_valid = 1'b1;
            bus_read = r;
            bus_fetch = f;
            bus_addr = a;
            bus_data = d;
            @(posedge sys_clk);
            #1;
            bus_valid = 1'b0;
            bus_fetch = 1'b0;
            bus_addr = ~a;
            bus_data = ~d;
        end
    endtask
endmodule // dbgct_cpu_model

// >>> dv/dbgct_regs_test.sv
`timescale 1ns/100ps
`include "dbgct_defs.vh"
module dbgct_regs_test;
    reg sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, secure = 1'b0;
    reg begin_trace = 1'b0, opcode_qualified_trigger = 1'b0;
    // Remaining trigger modes with a missing and a hitting cycle, entry 0 in the low bits
    reg [19:0] mode_tab = {`DBGCT_MODE_OUTSIDE, `DBGCT_MODE_INSIDE, `DBGCT_MODE_A_NOT_BDATA,
        `DBGCT_MODE_A_AND_BDATA, `DBGCT_MODE_A_THEN_B};
    reg [79:0] miss_addr = {16'h2800, 16'h1000, 16'h2040, 16'h2040, 16'h3000};
    reg [79:0] hit_addr = {16'h3001, 16'h2800, 16'h2040, 16'h2040, 16'h3000};
    reg [39:0] miss_data = {8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    reg [39:0] hit_data = {8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    reg [2:0] reg_sel = 3'h0;
    reg [7:0] reg_wdata = 8'h00, d, h;
    reg [3:0] trigger_mode = 4'h0;
    wire bus_valid, bus_read, bus_fetch, break_request, break_is_tag, armed_flag, match_a_flag, match_b_flag;
    wire [15:0] bus_addr;
    wire [7:0] bus_data, reg_rdata;
    wire [3:0] fifo_count;
    integer n_mismatch = 0, tests_run = 0, k, m;
    // Clock and instances
    always #25 sys_clk = ~sys_clk;
    dbgct_cpu_model u_cpu (.sys_clk(sys_clk), .bus_valid(bus_valid), .bus_read(bus_read),
        .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_data(bus_data));
    dbgct_regs DUT (.sys_clk(sys_clk), .reset(reset), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .secure(secure), .trigger_mode(trigger_mode),
        .begin_trace(begin_trace), .opcode_qualified_trigger(opcode_qualified_trigger),
        .bus_valid(bus_valid), .bus_read(bus_read),
        .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_data(bus_data), .break_request(break_request),
        .break_is_tag(break_is_tag), .armed_flag(armed_flag), .match_a_flag(match_a_flag),
        .match_b_flag(match_b_flag), .fifo_count(fifo_count));
    // Register port accesses, one strobe cycle each
    task wr(input [2:0] s, input [7:0] v);
        begin
            @(posedge sys_clk);
            #1;
            reg_sel = s;
            reg_wdata = v;
            reg_wr = 1'b1;
            @(posedge sys_clk);
            #1;
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [2:0] s);
        begin
            @(posedge sys_clk);
            #1;
            reg_sel = s;
            reg_rd = 1'b1;
            @(posedge sys_clk);
            #1;
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
    task chk8(input [7:0] g, input [7:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task chk1(input g, input e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        results;
    end
    // Test sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        for (k = 0; k < 7; k = k + 1) begin
            rd(k[2:0]);
            chk8(d, 8'h00);
        end
        wr(`DBGCT_IDX_CMP_A_HIGH, 8'h20);
        wr(`DBGCT_IDX_CMP_A_LOW, 8'h40);
        wr(3'h7, 8'hff);
        rd(3'h7);
        chk8(d, 8'h00);
        rd(`DBGCT_IDX_CMP_A_LOW);
        chk8(d, 8'h40);
        // Unarmed profiling, one fetch before each word read
        for (k = 0; k < 16; k = k + 1) begin
            u_cpu.cyc({8'h30 | k[7:0], ~k[7:0]}, 1'b1, 1'b1, 8'h00);
            if (k == 3)
                wr(`DBGCT_IDX_FIFO_LOW, 8'hff);
            rd(`DBGCT_IDX_FIFO_HIGH);
            h = d;
            rd(`DBGCT_IDX_FIFO_HIGH);
            chk8(d, h);
            rd(`DBGCT_IDX_FIFO_LOW);
            m = k - 8;
            chk8(h, k < 8 ? 8'h00 : 8'h30 | m[7:0]);
            chk8(d, k < 8 ? 8'h00 : ~m[7:0]);
        end
        // End trace on comparator A, reads only, tag break
        wr(`DBGCT_IDX_CONTROL, 8'hfc);
        wr(`DBGCT_IDX_CMP_A_HIGH, 8'h99);
        rd(`DBGCT_IDX_CMP_A_HIGH);
        chk8(d, 8'h20);
        rd(`DBGCT_IDX_CONTROL);
        chk8(d, 8'hfc);
        rd(`DBGCT_IDX_FIFO_LOW);
        h = d;
        rd(`DBGCT_IDX_FIFO_LOW);
        chk8(d, h);
        u_cpu.cyc(16'h2040, 1'b0, 1'b0, 8'h00);
        chk1(armed_flag, 1'b1);
        u_cpu.cyc(16'h2040, 1'b1, 1'b0, 8'h00);
        chk1(break_request, 1'b1);
        chk1(break_is_tag, 1'b1);
        chk1(match_a_flag & ~armed_flag, 1'b1);
        // Comparator B, writes only, force break
        trigger_mode = `DBGCT_MODE_A_OR_B;
        wr(`DBGCT_IDX_CONTROL, 8'hd1);
        u_cpu.cyc(16'h0000, 1'b1, 1'b0, 8'h00);
        chk1(armed_flag, 1'b1);
        u_cpu.cyc(16'h0000, 1'b0, 1'b0, 8'h00);
        chk1(break_request & match_b_flag, 1'b1);
        chk1(break_is_tag, 1'b0);
        // Event-only modes store bytes, begin trace forced
        for (k = 3; k < 5; k = k + 1) begin
            trigger_mode = k[3:0];
            wr(`DBGCT_IDX_CONTROL, k == 3 ? 8'hc0 : 8'hd0);
            u_cpu.cyc(16'h2040, 1'b1, 1'b0, 8'h55);
            for (m = 0; m < 8; m = m + 1) begin
                chk1(armed_flag, 1'b1);
                u_cpu.cyc(16'h0000, 1'b0, 1'b0, 8'ha0 + m[7:0]);
            end
            chk1(break_request, k == 4);
            chk1(armed_flag, 1'b0);
            chk8({4'h0, fifo_count}, 8'h08);
            rd(`DBGCT_IDX_FIFO_HIGH);
            chk8(d, 8'h00);
            for (m = 0; m < 8; m = m + 1) begin
                rd(`DBGCT_IDX_FIFO_LOW);
                chk8(d, 8'ha0 + m[7:0]);
            end
            rd(`DBGCT_IDX_FIFO_HIGH);
            chk8(d, 8'h00);
        end
        // Begin trace on an executed A opcode, then eight stored fetches
        trigger_mode = `DBGCT_MODE_A_ONLY;
        begin_trace = 1'b1;
        opcode_qualified_trigger = 1'b1;
        wr(`DBGCT_IDX_CONTROL, 8'hd0);
        u_cpu.cyc(16'h2040, 1'b1, 1'b0, 8'h00);
        chk1(match_a_flag, 1'b0);
        u_cpu.cyc(16'h2040, 1'b1, 1'b1, 8'h00);
        chk8({4'h0, fifo_count}, 8'h00);
        for (m = 0; m < 8; m = m + 1) begin
            chk1(armed_flag & ~break_request, 1'b1);
            u_cpu.cyc(16'h1000 + m[15:0], 1'b1, 1'b1, 8'h00);
        end
        chk8({4'h0, fifo_count}, 8'h08);
        chk1(break_request & ~armed_flag, 1'b1);
        for (m = 0; m < 8; m = m + 1) begin
            rd(`DBGCT_IDX_FIFO_HIGH);
            chk8(d, 8'h10);
            rd(`DBGCT_IDX_FIFO_LOW);
            chk8(d, m[7:0]);
        end
        begin_trace = 1'b0;
        opcode_qualified_trigger = 1'b0;
        // Remaining end trace modes: a miss keeps the run, a hit ends it
        wr(`DBGCT_IDX_CMP_B_HIGH, 8'h30);
        for (k = 0; k < 5; k = k + 1) begin
            trigger_mode = mode_tab[k*4 +: 4];
            wr(`DBGCT_IDX_CONTROL, 8'hd0);
            u_cpu.cyc(miss_addr[k*16 +: 16], 1'b1, 1'b0, miss_data[k*8 +: 8]);
            chk1(armed_flag, 1'b1);
            if (k == 0) begin
                u_cpu.cyc(16'h2040, 1'b1, 1'b0, 8'h00);
                chk1(armed_flag, 1'b1);
            end
            u_cpu.cyc(hit_addr[k*16 +: 16], 1'b1, 1'b0, hit_data[k*8 +: 8]);
            chk1(break_request & ~armed_flag, 1'b1);
        end
        // Enable refused while secure
        wr(`DBGCT_IDX_CONTROL, 8'h00);
        secure = 1'b1;
        wr(`DBGCT_IDX_CONTROL, 8'hc0);
        rd(`DBGCT_IDX_CONTROL);
        chk8(d, 8'h00);
        results;
    end
endmodule // dbgct_regs_test
